// File: logic/strap_pkg.sv
// Shared constants and types for the dual-port strap capture block.
package strap_pkg;

  // ****************************************
  // Geometry
  // ****************************************
  localparam int NPORTS = 2;
  localparam int ADDR_STRAP_W = 4;
  localparam int STA_W = 5;
  localparam int REG_W = 16;
  localparam int APB_ADDR_W = 8;
  localparam int APB_DATA_W = 32;

  typedef struct packed {
    logic fiber;
    logic autoneg_enable_strap;
    logic cap_hi;
    logic cap_lo;
  } strap_s;

  typedef struct packed {
    logic [STA_W-1:0] station_address;
    logic fiber;
    logic speed100;
    logic an_enable;
    logic full_duplex;
  } port_cfg_s;

  typedef enum {ST_CAPTURE, ST_RUN} ld_state_e;

  localparam int STRAP_W = $bits(strap_s);
  localparam int SYNC_W = 1 + ADDR_STRAP_W + NPORTS * STRAP_W;

  // ****************************************
  // Strap defaults (internal pull resistors)
  // ****************************************
  localparam logic [ADDR_STRAP_W-1:0] ADDR_STRAP_DEFAULT = 4'h0;
  localparam strap_s PORT_STRAP_DEFAULT = 4'h7;
  localparam logic HW_RESET_ACTIVE = 1'b0;

  // ****************************************
  // Basic mode control and advertisement fields
  // ****************************************
  localparam int BMCR_SPEED_BIT = 13;
  localparam int BMCR_AN_BIT = 12;
  localparam int BMCR_DUPLEX_BIT = 8;
  localparam int ANAR_ABILITY_LSB = 5;
  localparam logic [REG_W-1:0] ANAR_SELECTOR = 16'h0001;
  localparam logic [REG_W-1:0] BMCR_RST = 16'h3100;
  localparam logic [REG_W-1:0] ANAR_RST = 16'h0101;
  localparam port_cfg_s CFG_RST = 9'h007;

  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [APB_ADDR_W-1:0] OFF_CTRL0 = 8'h00;
  localparam logic [APB_ADDR_W-1:0] OFF_BMCR0 = 8'h08;
  localparam logic [APB_ADDR_W-1:0] OFF_ANAR0 = 8'h10;
  localparam logic [APB_ADDR_W-1:0] OFF_STATUS = 8'h18;
  localparam logic [APB_ADDR_W-1:0] PORT_STRIDE = 8'h04;
  localparam int STAT_HW_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_FIBER_LSB = 2;

endpackage

// File: logic/strap_decode.sv
// Turns one port's captured mode straps into control and advert values.
`timescale 1ns/1ps
module strap_decode
  import strap_pkg::*;
(
  input wire strap_s strap,
  output logic [REG_W-1:0] bmcr,
  output logic [REG_W-1:0] anar
);

  always_comb
  begin
    bmcr = '0;
    anar = ANAR_SELECTOR;
    if (strap.fiber)
    begin
      // Fiber runs at 100 only and never negotiates, so the
      // negotiation strap and the high select are ignored.
      bmcr[BMCR_SPEED_BIT] = 1'b1;
      bmcr[BMCR_DUPLEX_BIT] = strap.cap_lo;
    end
    else
    begin
      bmcr[BMCR_SPEED_BIT] = strap.cap_hi;
      bmcr[BMCR_DUPLEX_BIT] = strap.cap_lo;
      bmcr[BMCR_AN_BIT] = strap.autoneg_enable_strap;
      if (strap.autoneg_enable_strap)
      begin
        anar[ANAR_ABILITY_LSB + {strap.cap_hi, strap.cap_lo}] = 1'b1;
      end
    end
  end

endmodule // strap_decode

// File: logic/strap_latch.sv
// Strap capture, configuration registers and APB slave for two ports.
`timescale 1ns/1ps
module strap_latch
  import strap_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic HW_RESET_N,
  input wire logic [ADDR_STRAP_W-1:0] ADDR_STRAP,
  input wire strap_s [NPORTS-1:0] PORT_STRAP,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [APB_ADDR_W-1:0] PADDR,
  input wire logic [APB_DATA_W-1:0] PWDATA,
  output logic [APB_DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  output port_cfg_s [NPORTS-1:0] PORT_CFG,
  output logic FUNC_OE
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  // open straps read default
  localparam logic [SYNC_W-1:0] SYNC_RST =
    {HW_RESET_ACTIVE, ADDR_STRAP_DEFAULT, {NPORTS{PORT_STRAP_DEFAULT}}};

  logic [SYNC_W-1:0] raw, s1, s2, s3;
  logic [SYNC_W-1:0] stable, next_stable;
  logic hw_n_live, hw_active;
  logic [ADDR_STRAP_W-1:0] addr_live;
  strap_s [NPORTS-1:0] port_live;

  assign raw = {HW_RESET_N, ADDR_STRAP, PORT_STRAP};
  assign {hw_n_live, addr_live, port_live} = stable;
  assign hw_active = (hw_n_live == HW_RESET_ACTIVE);

  // A level only counts once the second and third stages agree, which
  // rejects a single sample caught mid-transition.
  for (genvar b = 0; b < SYNC_W; b++)
  begin : g_filt
    assign next_stable[b] = (s2[b] == s3[b]) ? s3[b] : stable[b];
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      s1 <= SYNC_RST;
      s2 <= SYNC_RST;
      s3 <= SYNC_RST;
      stable <= SYNC_RST;
    end
    else if (CE)
    begin
      s1 <= raw;
      s2 <= s1;
      s3 <= s2;
      stable <= next_stable;
    end
  end

  // ****************************************
  // Strap decode per port
  // ****************************************
  logic [NPORTS-1:0][REG_W-1:0] dec_bmcr, dec_anar;
  logic [NPORTS-1:0][STA_W-1:0] sta;
  logic [ADDR_STRAP_W-1:0] cap_addr;
  strap_s [NPORTS-1:0] cap_port;

  for (genvar p = 0; p < NPORTS; p++)
  begin : g_port
    strap_decode u_dec (
      .strap(port_live[p]),
      .bmcr(dec_bmcr[p]),
      .anar(dec_anar[p])
    );
    // low address bit from port index
    assign sta[p] = {cap_addr, 1'(p)};
  end

  // ****************************************
  // Capture sequencer and configuration
  // ****************************************
  ld_state_e st, next_st;
  logic [ADDR_STRAP_W-1:0] next_cap_addr;
  strap_s [NPORTS-1:0] next_cap_port;
  logic [NPORTS-1:0][REG_W-1:0] bmcr, anar, next_bmcr, next_anar;
  logic [NPORTS-1:0] hit_bmcr, hit_anar;
  port_cfg_s [NPORTS-1:0] next_cfg;
  logic next_func_oe;
  logic wr_en;

  assign wr_en = PSEL && PENABLE && PREADY && PWRITE;

  always_comb
  begin
    next_st = st;
    next_cap_addr = cap_addr;
    next_cap_port = cap_port;
    next_bmcr = bmcr;
    next_anar = anar;
    unique case (st)
      ST_CAPTURE:
      begin
        // follow the straps for as long as reset is held
        next_cap_addr = addr_live;
        next_cap_port = port_live;
        // straps seed control and advert registers
        next_bmcr = dec_bmcr;
        next_anar = dec_anar;
        // the sample taken in the cycle that sees release is kept
        if (!hw_active)
        begin
          next_st = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (hw_active)
        begin
          next_st = ST_CAPTURE;
        end
        else if (wr_en)
        begin
          for (int p = 0; p < NPORTS; p++)
          begin
            if (hit_bmcr[p])
            begin
              next_bmcr[p] = PWDATA[REG_W-1:0];
              // software cannot lift a fiber port off 100 Mb
              if (cap_port[p].fiber)
              begin
                next_bmcr[p][BMCR_SPEED_BIT] = 1'b1;
                next_bmcr[p][BMCR_AN_BIT] = 1'b0;
              end
            end
            if (hit_anar[p])
            begin
              next_anar[p] = PWDATA[REG_W-1:0];
            end
          end
        end
      end
    endcase
  end

  always_comb
  begin
    for (int p = 0; p < NPORTS; p++)
    begin
      // captured straps form the station address
      next_cfg[p].station_address = sta[p];
      next_cfg[p].fiber = cap_port[p].fiber;
      next_cfg[p].speed100 = bmcr[p][BMCR_SPEED_BIT];
      next_cfg[p].an_enable = bmcr[p][BMCR_AN_BIT];
      next_cfg[p].full_duplex = bmcr[p][BMCR_DUPLEX_BIT];
    end
    // pins go back to their own function only after release
    next_func_oe = (next_st == ST_RUN);
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      st <= ST_CAPTURE;
      cap_addr <= ADDR_STRAP_DEFAULT;
      cap_port <= {NPORTS{PORT_STRAP_DEFAULT}};
      bmcr <= {NPORTS{BMCR_RST}};
      anar <= {NPORTS{ANAR_RST}};
      FUNC_OE <= 1'b0;
      for (int p = 0; p < NPORTS; p++)
      begin
        PORT_CFG[p] <= CFG_RST;
        PORT_CFG[p].station_address[0] <= 1'(p);
      end
    end
    else if (CE)
    begin
      st <= next_st;
      cap_addr <= next_cap_addr;
      cap_port <= next_cap_port;
      bmcr <= next_bmcr;
      anar <= next_anar;
      FUNC_OE <= next_func_oe;
      PORT_CFG <= next_cfg;
    end
  end

  // ****************************************
  // APB slave
  // ****************************************
  logic [APB_DATA_W-1:0] next_prdata;
  logic next_pready, next_pslverr, setup;

  assign setup = PSEL && !PENABLE;

  // Read data is taken at the setup cycle, so the answer costs one
  // wait-free access phase and needs no combinational output path.
  always_comb
  begin
    next_prdata = PRDATA;
    next_pslverr = PSLVERR;
    next_pready = setup;
    hit_bmcr = '0;
    hit_anar = '0;
    if (setup)
    begin
      next_prdata = '0;
      next_pslverr = 1'b1;
    end
    for (int p = 0; p < NPORTS; p++)
    begin
      hit_bmcr[p] = (PADDR == OFF_BMCR0 + 8'(p) * PORT_STRIDE);
      hit_anar[p] = (PADDR == OFF_ANAR0 + 8'(p) * PORT_STRIDE);
      if (setup && PADDR == OFF_CTRL0 + 8'(p) * PORT_STRIDE)
      begin
        next_prdata = APB_DATA_W'(sta[p]);
        next_pslverr = 1'b0;
      end
      if (setup && hit_bmcr[p])
      begin
        next_prdata = APB_DATA_W'(bmcr[p]);
        next_pslverr = 1'b0;
      end
      if (setup && hit_anar[p])
      begin
        next_prdata = APB_DATA_W'(anar[p]);
        next_pslverr = 1'b0;
      end
      if (setup && PADDR == OFF_STATUS)
      begin
        next_prdata[STAT_FIBER_LSB + p] = cap_port[p].fiber;
      end
    end
    if (setup && PADDR == OFF_STATUS)
    begin
      next_prdata[STAT_HW_BIT] = hw_active;
      next_prdata[STAT_RUN_BIT] = (st == ST_RUN);
      next_pslverr = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      PRDATA <= '0;
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
    else if (CE)
    begin
      PRDATA <= next_prdata;
      PREADY <= next_pready;
      PSLVERR <= next_pslverr;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);

  sequence capture_s;
    st == ST_CAPTURE && CE;
  endsequence
  sequence release_s;
    st == ST_CAPTURE && !hw_active && CE;
  endsequence
  addr_lsb_fixed_a: assert property (
    PORT_CFG[0].station_address[0] == 1'b0 &&
    PORT_CFG[1].station_address[0] == 1'b1)
    else $error("station address low bit does not match port");
  addr_upper_shared_a: assert property (
    PORT_CFG[0].station_address[STA_W-1:1] ==
    PORT_CFG[1].station_address[STA_W-1:1])
    else $error("ports disagree on upper address bits");
  addr_capture_a: assert property (
    capture_s |=> cap_addr == $past(addr_live))
    else $error("address straps not captured during reset");
  config_hold_a: assert property (
    (st == ST_RUN && !hw_active) |=>
      $stable(cap_addr) && $stable(cap_port))
    else $error("latched straps changed outside reset");
  fiber_speed_a: assert property (
    (capture_s ##1 CE) |=>
      !(PORT_CFG[0].fiber && (!PORT_CFG[0].speed100 ||
        PORT_CFG[0].an_enable)))
    else $error("fiber port not fixed at 100 Mb without negotiation");
  fiber_duplex_a: assert property (
    (capture_s and port_live[0].fiber) |=>
      bmcr[0][BMCR_DUPLEX_BIT] == $past(port_live[0].cap_lo))
    else $error("fiber duplex not taken from low select");
  fiber_ignore_a: assert property (
    (capture_s and port_live[1].fiber) |=>
      !bmcr[1][BMCR_AN_BIT] && bmcr[1][BMCR_SPEED_BIT])
    else $error("fiber port honoured negotiation or high select");
  forced_mode_a: assert property (
    (capture_s and !port_live[0].fiber && !port_live[0].autoneg_enable_strap) |=>
      !bmcr[0][BMCR_AN_BIT] &&
      bmcr[0][BMCR_SPEED_BIT] == $past(port_live[0].cap_hi))
    else $error("forced mode not set from select straps");
  autoneg_on_a: assert property (
    (capture_s and !port_live[1].fiber && port_live[1].autoneg_enable_strap) |=>
      bmcr[1][BMCR_AN_BIT])
    else $error("negotiation strap did not enable negotiation");
  advert_seed_a: assert property (
    capture_s |=> anar == $past(dec_anar))
    else $error("advert register not seeded from straps");
  pins_release_a: assert property (
    release_s |=> FUNC_OE)
    else $error("functional drive not restored after release");

endmodule // strap_latch

// File: tb/strap_pull.sv
// Board strap resistors, plus the pins' own drive once they are released.
`timescale 1ns/1ps
module strap_pull
  import strap_pkg::*;
(
  input wire logic clk,
  input wire logic func_oe,
  input wire logic fitted,
  input wire logic [ADDR_STRAP_W-1:0] addr_lvl,
  input wire strap_s [NPORTS-1:0] port_lvl,
  output logic [ADDR_STRAP_W-1:0] addr_pin,
  output strap_s [NPORTS-1:0] port_pin
);
  // ****************************************
  // Pin levels
  // ****************************************
  logic [11:0] pattern;
  logic [11:0] next_pattern;

  // Traffic on the shared pins changes every cycle, so a leaky latch shows.
  always_comb next_pattern = ~{pattern[10:0], pattern[11]};

  always_ff @(posedge clk or negedge func_oe)
  begin
    if (!func_oe)
      pattern <= 12'h000;
    else
      pattern <= next_pattern;
  end

  always_comb
  begin
    if (func_oe === 1'b1)
      {addr_pin, port_pin} = pattern;
    else if (fitted)
    begin
      addr_pin = addr_lvl;
      port_pin = port_lvl;
    end
    else
    begin
      addr_pin = 4'h0;
      port_pin = {2{strap_s'(4'h7)}};
    end
  end
endmodule // strap_pull

// File: tb/tb.sv
// Self-checking bench for the strap capture block.
`timescale 1ns/1ps
module tb;
  import strap_pkg::*;
  logic CLK_SYS, RST_N, HW_RESET_N, PSEL, PENABLE, PWRITE;
  logic PREADY, PSLVERR, FUNC_OE, fit, er, ce;
  logic [APB_ADDR_W-1:0] PADDR;
  logic [APB_DATA_W-1:0] PWDATA, PRDATA, rd;
  logic [ADDR_STRAP_W-1:0] ADDR_STRAP, addr, ea;
  strap_s [NPORTS-1:0] PORT_STRAP, lvl;
  strap_s sa, sb;
  port_cfg_s [NPORTS-1:0] PORT_CFG;
  int errors, checks, n;

  strap_latch dut_u (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .CE(ce),
    .HW_RESET_N(HW_RESET_N), .ADDR_STRAP(ADDR_STRAP),
    .PORT_STRAP(PORT_STRAP), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .PORT_CFG(PORT_CFG),
    .FUNC_OE(FUNC_OE));

  strap_pull pull_u (.clk(CLK_SYS), .func_oe(FUNC_OE), .fitted(fit),
    .addr_lvl(addr), .port_lvl(lvl), .addr_pin(ADDR_STRAP),
    .port_pin(PORT_STRAP));

  initial
  begin
    CLK_SYS = 1'b0;
    forever #2 CLK_SYS = ~CLK_SYS;
  end

  // ****************************************
  // Tasks and expected values
  // ****************************************
  task automatic finish_test();
    if (errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Ready, read data and error are taken at the rising edge that sees
  // ready high; values read right after the edge are the ones it saw.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge CLK_SYS);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK_SYS);
    PENABLE <= 1'b1;
    @(posedge CLK_SYS);
    while (PREADY !== 1'b1 && k < 20)
    begin
      k++;
      @(posedge CLK_SYS);
    end
    if (k == 20)
      errors++;
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, rd);
  endtask

  function automatic logic [15:0] eb(input strap_s s);
    logic [15:0] b;
    b = 16'h0000;
    b[BMCR_SPEED_BIT] = s.fiber | s.cap_hi;
    b[BMCR_AN_BIT] = s.autoneg_enable_strap & ~s.fiber;
    b[BMCR_DUPLEX_BIT] = s.cap_lo;
    return b;
  endfunction

  function automatic logic [15:0] ean(input strap_s s);
    if (s.autoneg_enable_strap && !s.fiber)
      return (16'h0001 << (5 + {s.cap_hi, s.cap_lo})) | 16'h0001;
    return 16'h0001;
  endfunction

  function automatic logic [31:0] ecfg(input logic p, input strap_s s);
    logic [15:0] b;
    b = eb(s);
    return {23'h0, ea, p, s.fiber, b[13], b[12], b[8]};
  endfunction

  initial
  begin
    #100000;
    errors++;
    finish_test();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    errors = 0;
    checks = 0;
    RST_N = 1'b0;
    HW_RESET_N = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 8'h00;
    PWDATA = 32'h0;
    fit = 1'b0;
    ce = 1'b1;
    addr = 4'h0;
    lvl = 8'h00;
    repeat (8) @(posedge CLK_SYS);
    RST_N <= 1'b1;
    // Case 0 has no resistors; the rest walk every mode code on both ports.
    for (int k = 0; k < 17; k++)
    begin
      sa = (k != 0) ? strap_s'(4'(k - 1)) : strap_s'(4'h7);
      sb = (k != 0) ? strap_s'(~4'(k - 1)) : strap_s'(4'h7);
      ea = (k != 0) ? 4'(k + 5) : 4'h0;
      @(posedge CLK_SYS);
      HW_RESET_N <= 1'b0;
      fit <= (k != 0);
      addr <= ea;
      lvl <= {sb, sa};
      repeat (5) @(posedge CLK_SYS);
      apb(1'b0, OFF_STATUS, 32'h0);
      chk("status capture", 32'h1, rd & 32'h3);
      chk("oe capture", 32'h0, {31'h0, FUNC_OE});
      HW_RESET_N <= 1'b1;
      n = 0;
      @(negedge CLK_SYS);
      while (FUNC_OE !== 1'b1 && n < 20)
      begin
        n++;
        @(negedge CLK_SYS);
      end
      chk("oe run", 32'h1, {31'h0, FUNC_OE});
      repeat (2) @(posedge CLK_SYS);
      chk("cfg a", ecfg(1'b0, sa), {23'h0, PORT_CFG[0]});
      chk("cfg b", ecfg(1'b1, sb), {23'h0, PORT_CFG[1]});
      rdchk("ctrl a", OFF_CTRL0, {27'h0, ea, 1'b0});
      rdchk("ctrl b", OFF_CTRL0 + PORT_STRIDE, {27'h0, ea, 1'b1});
      rdchk("bmcr a", OFF_BMCR0, {16'h0, eb(sa)});
      rdchk("bmcr b", OFF_BMCR0 + PORT_STRIDE, {16'h0, eb(sb)});
      rdchk("anar a", OFF_ANAR0, {16'h0, ean(sa)});
      rdchk("anar b", OFF_ANAR0 + PORT_STRIDE, {16'h0, ean(sb)});
      rdchk("status", OFF_STATUS, {28'h0, sb.fiber, sa.fiber, 2'b10});
      chk("cfg hold a", ecfg(1'b0, sa), {23'h0, PORT_CFG[0]});
      chk("cfg hold b", ecfg(1'b1, sb), {23'h0, PORT_CFG[1]});
    end
    apb(1'b1, OFF_BMCR0, 32'h1000);
    rdchk("bmcr fiber wr", OFF_BMCR0, 32'h2000);
    apb(1'b1, OFF_BMCR0 + PORT_STRIDE, 32'h0100);
    rdchk("bmcr copper wr", OFF_BMCR0 + PORT_STRIDE, 32'h0100);
    apb(1'b1, OFF_CTRL0, 32'h0);
    rdchk("ctrl wr", OFF_CTRL0, {27'h0, ea, 1'b0});
    // A hardware reset pulse while the clock enable is low must leave
    // no trace, since the synchronisers are frozen as well.
    ce <= 1'b0;
    HW_RESET_N <= 1'b0;
    repeat (8) @(posedge CLK_SYS);
    HW_RESET_N <= 1'b1;
    @(posedge CLK_SYS);
    ce <= 1'b1;
    repeat (8) @(posedge CLK_SYS);
    chk("ce hold a", {23'h0, ea, 5'b01100}, {23'h0, PORT_CFG[0]});
    rdchk("ce status", OFF_STATUS, {28'h0, sb.fiber, sa.fiber, 2'b10});
    rdchk("unmapped", 8'h1c, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    finish_test();
  end
endmodule // tb
